// ### shared/cmr_map.vh
`ifndef CMR_MAP_VH
`define CMR_MAP_VH

// ----------------------------------------
// Bus register byte offsets
// ----------------------------------------
`define CMR_OFS_PC     12'h000
`define CMR_OFS_PSW    12'h004
`define CMR_OFS_SP     12'h008
`define CMR_OFS_CMD    12'h00C
`define CMR_OFS_STAT   12'h010
`define CMR_OFS_MASK   12'h014
`define CMR_OFS_PROBE  12'h018
`define CMR_OFS_GPR    12'h020
`define CMR_OFS_PAIR   12'h040
`define CMR_OFS_TBL    12'h400
`define CMR_OFS_RAM    12'h800

// ----------------------------------------
// Status word fields and reset values
// ----------------------------------------
`define CMR_PSW_IE     7
`define CMR_PSW_Z      6
`define CMR_PSW_AC     4
`define CMR_PSW_CY     0
`define CMR_PSW_RST    8'h02
`define CMR_SP_RST     16'h0000
`define CMR_MASK_RST   16'hFFFF
`define CMR_STAT_SERR  0

// ----------------------------------------
// Address map
// ----------------------------------------
`define CMR_VEC_RESET  16'h0000
`define CMR_VEC_WDT    16'h0004
`define CMR_VEC_SRC0   16'h0006
`define CMR_VEC_LAST   16'h0021
`define CMR_TABLE_CALL_INSTRUCTION_LO   16'h0040
`define CMR_TABLE_CALL_INSTRUCTION_HI   16'h007F
`define CMR_DISP_LO    16'hFA00
`define CMR_DISP_HI_S  16'hFA04
`define CMR_DISP_HI_L  16'hFA0E
`define CMR_HSRAM_LO   16'hFD00
`define CMR_HSRAM_HI   16'hFEFF
`define CMR_SFR_LO     16'hFF00

// ----------------------------------------
// Region codes returned by the probe
// ----------------------------------------
`define CMR_RGN_VEC    3'h0
`define CMR_RGN_TABLE_CALL_INSTRUCTION  3'h1
`define CMR_RGN_PROG   3'h2
`define CMR_RGN_DISP   3'h3
`define CMR_RGN_HSRAM  3'h4
`define CMR_RGN_SFR    3'h5
`define CMR_RGN_NONE   3'h6

// ----------------------------------------
// Command opcodes
// ----------------------------------------
`define CMR_OP_ADV     8'h01
`define CMR_OP_BRIMM   8'h02
`define CMR_OP_BRPAIR  8'h03
`define CMR_OP_TCALL   8'h04
`define CMR_OP_PUSHPSW 8'h05
`define CMR_OP_POPPSW  8'h06
`define CMR_OP_IRET    8'h07
`define CMR_OP_MASKALL 8'h08
`define CMR_OP_UNMASK  8'h09
`define CMR_OP_ADD     8'h10
`define CMR_OP_SUB     8'h11
`define CMR_OP_ROR     8'h12
`define CMR_OP_ROL     8'h13
`define CMR_OP_MOV1    8'h14
`define CMR_OP_AND1    8'h15
`define CMR_OP_LDREG   8'h16

`endif

// ### hdl/cmr_cpu_regs.v
`timescale 1ns/100ps
`include "cmr_map.vh"

// Contract
// [RULE_01] Decode a flat 64 KB space from 16-bit addresses.
// [RULE_02] Bytes 0000H to 0021H form the vector table.
// [RULE_03] Vector low byte comes from the even address, high byte from the odd.
// [RULE_04] Reset slot 0000H, watchdog 0004H, other sources on even slots to 0020H; with NUM_SRC 15 the last source lands on 0022H.
// [RULE_05] Table call takes its entry from 0040H to 007FH.
// [RULE_06] Fast RAM sits at FD00H to FEFFH and holds the stack.
// [RULE_07] Display RAM starts at FA00H, ends FA04H or FA0EH, usable as RAM; the code only decodes the region and stores nothing there.
// [RULE_08] Peripheral registers occupy FF00H to FFFFH.
// [RULE_09] Counter advances by instruction length or loads the branch target.
// [RULE_10] Reset loads the counter from 0000H low and 0001H high.
// [RULE_11] Status word pushed on interrupt entry and push, popped on returns.
// [RULE_12] Reset loads the status word with 02H.
// [RULE_13] Enable flag low refuses maskable requests; high defers to each mask.
// [RULE_14] Enable flag cleared by mask-all and acknowledge, set by unmask-all.
// [RULE_15] Zero flag follows a zero result.
// [RULE_16] Half-carry flag follows carry or borrow at bit 3.
// [RULE_17] Carry takes overflow, rotate shift-out, and bit accumulator duty.
// [RULE_18] Stack pointer holds the stack address, only inside fast RAM; reset and bus writes can leave it outside, where stack accesses are refused.
// [RULE_19] Pointer decrements before a stack write, increments after a read.
// [RULE_20] Software loads the stack pointer before using the stack.
// [RULE_21] Eight 8-bit registers, pairable into four 16-bit pairs.
// [RULE_22] Registers reachable by index 0 to 7, pairs by index 0 to 3.
// [RULE_23] Pair n has register 2n low and register 2n+1 high.
// [RULE_24] Reset initialises counter, status word and stack pointer.
module cmr_cpu_regs #(
	parameter NUM_SRC    = 15,
	parameter LARGE_DISP = 1
) (
	// Clock and reset
	input  wire               core_clk,
	input  wire               rst,
	// AHB-Lite slave
	input  wire               hsel,
	input  wire [31:0]        haddr,
	input  wire [1:0]         htrans,
	input  wire               hwrite,
	input  wire [2:0]         hsize,
	input  wire [31:0]        hwdata,
	input  wire               hready,
	output reg  [31:0]        hrdata,
	output reg                hreadyout,
	output reg                hresp,
	// Interrupt sources, asynchronous; maskable ones as levels, watchdog on its rising edge
	input  wire [NUM_SRC-1:0] irqReq,
	input  wire               wdtReq,
	output reg                intAck
);

	// ----------------------------------------
	// Architectural state
	// ----------------------------------------
	reg [15:0]        pc;
	reg [15:0]        sp;
	reg [7:0]         program_status_word;
	reg [7:0]         gpr [0:7];
	reg [7:0]         tbl [0:127];
	reg [7:0]         ram [0:511];
	reg [15:0]        irqMask;
	reg [15:0]        probe;
	reg               stkErr;
	reg               vecPend;
	reg [NUM_SRC-1:0] irqS1;
	reg [NUM_SRC-1:0] irqS2;
	reg               wdtS1;
	reg               wdtS2;
	reg               wdtS3;

	// ----------------------------------------
	// Bus data phase
	// ----------------------------------------
	reg        wrPend;
	reg        rdPend;
	reg        dHit;
	reg [11:0] dAddr;

	wire        addrOk   = hsel && htrans[1] && hready;
	wire [11:0] ofsGpr   = `CMR_OFS_GPR;
	wire [11:0] ofsPair  = `CMR_OFS_PAIR;
	wire [11:0] ofsTbl   = `CMR_OFS_TBL;
	wire [11:0] ofsRam   = `CMR_OFS_RAM;
	wire        wEn      = wrPend && dHit;
	wire        isGpr    = dAddr[11:5] == ofsGpr[11:5];
	wire        isPair   = dAddr[11:4] == ofsPair[11:4];
	wire        isTbl    = dAddr[11:9] == ofsTbl[11:9];
	wire        isRam    = dAddr[11] == ofsRam[11];
	wire        cmdGo    = wEn && dAddr == `CMR_OFS_CMD;
	wire [7:0]  op       = hwdata[7:0];
	wire [7:0]  arg      = hwdata[15:8];
	wire [15:0] dat      = hwdata[31:16];

	// ----------------------------------------
	// Address map decode
	// ----------------------------------------
	wire [15:0] dispHi = LARGE_DISP ? `CMR_DISP_HI_L : `CMR_DISP_HI_S;

	// Whole 16-bit space, so every address gets one code; the gap from the display RAM end to FD00H gets CMR_RGN_NONE
	function [2:0] regionOf;
		input [15:0] a;
		begin
			if (a <= `CMR_VEC_LAST)                               // [RULE_02]
				regionOf = `CMR_RGN_VEC;
			else if (a >= `CMR_TABLE_CALL_INSTRUCTION_LO && a <= `CMR_TABLE_CALL_INSTRUCTION_HI)    // [RULE_05]
				regionOf = `CMR_RGN_TABLE_CALL_INSTRUCTION;
			else if (a >= `CMR_DISP_LO && a <= dispHi)            // [RULE_07]
				regionOf = `CMR_RGN_DISP;
			else if (a >= `CMR_HSRAM_LO && a <= `CMR_HSRAM_HI)    // [RULE_06]
				regionOf = `CMR_RGN_HSRAM;
			else if (a >= `CMR_SFR_LO)                            // [RULE_08]
				regionOf = `CMR_RGN_SFR;
			else if (a < `CMR_DISP_LO)
				regionOf = `CMR_RGN_PROG;
			else
				regionOf = `CMR_RGN_NONE;
		end
	endfunction

	// Vector pair from the table store, low byte at the even index
	function [15:0] vecAt;
		input [6:0] i;
		begin
			vecAt = {tbl[i + 7'h01], tbl[i]};                     // [RULE_03]
		end
	endfunction

	// ----------------------------------------
	// Stack addressing
	// ----------------------------------------
	wire [15:0] hsLo     = `CMR_HSRAM_LO;
	wire [15:0] pushAddr = sp - 16'h0001;
	wire [15:0] pushOfs  = pushAddr - hsLo;
	wire [15:0] popOfs   = sp - hsLo;
	// Accesses that would leave fast RAM are refused and flagged
	wire pushOk = regionOf(pushAddr) == `CMR_RGN_HSRAM;   // [RULE_18]
	wire popOk  = regionOf(sp) == `CMR_RGN_HSRAM;         // [RULE_18]
	wire [7:0] popData = ram[popOfs[8:0]];

	// ----------------------------------------
	// Interrupt selection
	// ----------------------------------------
	reg  [NUM_SRC-1:0] acc;
	reg  [6:0]         srcIdx;
	reg                take;
	reg                pushReq;
	reg                popReq;
	wire [15:0]        vSrc0   = `CMR_VEC_SRC0;
	wire [15:0]        vWdt    = `CMR_VEC_WDT;
	wire [15:0]        vRst    = `CMR_VEC_RESET;
	wire               wdtEdge = wdtS2 && !wdtS3;
	integer            k;

	// Watchdog wins, then the lowest source index; commands and the reset fetch go first
	always @* begin
		acc = irqS2 & ~irqMask[NUM_SRC-1:0];
		srcIdx = vSrc0[6:0];
		for (k = NUM_SRC - 1; k >= 0; k = k - 1) begin
			if (acc[k]) begin
				srcIdx = vSrc0[6:0] + {k[5:0], 1'b0};          // [RULE_04]
			end
		end
		if (wdtEdge)
			srcIdx = vWdt[6:0];                                // [RULE_04]
		take = !cmdGo && !vecPend &&
			(wdtEdge || (program_status_word[`CMR_PSW_IE] && |acc));           // [RULE_13]
		pushReq = take || (cmdGo && op == `CMR_OP_PUSHPSW);
		popReq = cmdGo && (op == `CMR_OP_POPPSW || op == `CMR_OP_IRET);
	end

	// ----------------------------------------
	// Arithmetic for flag updates
	// ----------------------------------------
	wire [2:0] dst    = arg[2:0];
	wire [2:0] src    = arg[5:3];
	wire [7:0] opA    = gpr[dst];
	wire [7:0] opB    = gpr[src];
	wire [8:0] addRes = {1'b0, opA} + {1'b0, opB};
	wire [4:0] addLow = {1'b0, opA[3:0]} + {1'b0, opB[3:0]};
	wire [8:0] subRes = {1'b0, opA} - {1'b0, opB};
	wire [4:0] subLow = {1'b0, opA[3:0]} - {1'b0, opB[3:0]};
	wire       bitVal = opA[src];
	wire [15:0] ctBase = `CMR_TABLE_CALL_INSTRUCTION_LO;
	wire [6:0]  ctIdx  = ctBase[6:0] + {1'b0, arg[4:0], 1'b0};

	// ----------------------------------------
	// Read multiplexer
	// ----------------------------------------
	reg [31:0] rdMux;

	// Unmapped addresses read as zero
	always @* begin
		rdMux = 32'h00000000;
		if (isTbl)
			rdMux[7:0] = tbl[dAddr[8:2]];
		else if (isRam)
			rdMux[7:0] = ram[dAddr[10:2]];
		else if (isGpr)
			rdMux[7:0] = gpr[dAddr[4:2]];                      // [RULE_22]
		else if (isPair)
			rdMux[15:0] = {gpr[{dAddr[3:2], 1'b1}], gpr[{dAddr[3:2], 1'b0}]}; // [RULE_23]
		else begin
			case (dAddr)
				`CMR_OFS_PC:    rdMux[15:0] = pc;
				`CMR_OFS_PSW:   rdMux[7:0] = program_status_word;
				`CMR_OFS_SP:    rdMux[15:0] = sp;
				`CMR_OFS_STAT:  rdMux = {irqS2, {(16 - NUM_SRC){1'b0}}, 13'h0000, wdtS2, vecPend, stkErr};
				`CMR_OFS_MASK:  rdMux[15:0] = irqMask;
				`CMR_OFS_PROBE: rdMux = {13'h0000, regionOf(probe), probe}; // [RULE_01]
				default:        rdMux = 32'h00000000;
			endcase
		end
		if (!dHit)
			rdMux = 32'h00000000;
	end

	// ----------------------------------------
	// AHB-Lite slave handshake
	// ----------------------------------------
	// Reads take one wait state so that a write just before them is seen
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wrPend <= 1'b0;
			rdPend <= 1'b0;
			dHit <= 1'b0;
			dAddr <= 12'h000;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hresp <= 1'b0;
			if (rdPend) begin
				hrdata <= rdMux;
				hreadyout <= 1'b1;
				rdPend <= 1'b0;
				wrPend <= 1'b0;
			end else begin
				wrPend <= addrOk && hwrite;
				rdPend <= addrOk && !hwrite;
				hreadyout <= !(addrOk && !hwrite);
				if (addrOk) begin
					dHit <= haddr[31:12] == 20'h00000;
					dAddr <= {haddr[11:2], 2'b00};
				end
			end
		end
	end

	// ----------------------------------------
	// Memory write ports
	// ----------------------------------------
	// Table and RAM keep contents through reset
	always @(posedge core_clk) begin
		if (wEn && isTbl)
			tbl[dAddr[8:2]] <= hwdata[7:0];
		if (wEn && isRam)
			ram[dAddr[10:2]] <= hwdata[7:0];                   // [RULE_06]
		if (pushReq && pushOk)
			ram[pushOfs[8:0]] <= program_status_word;                          // [RULE_11]
	end

	// ----------------------------------------
	// Processor registers
	// ----------------------------------------
	integer r;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin                                         // [RULE_24]
			pc <= 16'h0000;
			sp <= `CMR_SP_RST;
			program_status_word <= `CMR_PSW_RST;                               // [RULE_12]
			for (r = 0; r < 8; r = r + 1) begin
				gpr[r] <= 8'h00;
			end
			irqMask <= `CMR_MASK_RST;
			probe <= 16'h0000;
			stkErr <= 1'b0;
			vecPend <= 1'b1;
			intAck <= 1'b0;
			irqS1 <= {NUM_SRC{1'b0}};
			irqS2 <= {NUM_SRC{1'b0}};
			wdtS1 <= 1'b0;
			wdtS2 <= 1'b0;
			wdtS3 <= 1'b0;
		end else begin
			irqS1 <= irqReq;
			irqS2 <= irqS1;
			wdtS1 <= wdtReq;
			wdtS2 <= wdtS1;
			wdtS3 <= wdtS2;
			intAck <= take;
			// A refused stack access beats a clear in the same cycle
			if ((pushReq && !pushOk) || (popReq && !popOk))
				stkErr <= 1'b1;                                // [RULE_18]
			else if (wEn && dAddr == `CMR_OFS_STAT && hwdata[`CMR_STAT_SERR])
				stkErr <= 1'b0;
			if (vecPend) begin
				pc <= vecAt(vRst[6:0]);                        // [RULE_10]
				vecPend <= 1'b0;
			end else if (take) begin
				pc <= vecAt(srcIdx);                           // [RULE_04]
				program_status_word[`CMR_PSW_IE] <= 1'b0;                      // [RULE_14]
				if (pushOk)
					sp <= pushAddr;                            // [RULE_19]
			end else if (cmdGo) begin
				case (op)
					`CMR_OP_ADV:
						pc <= pc + {13'h0000, arg[2:0]};       // [RULE_09]
					`CMR_OP_BRIMM:
						pc <= dat;                             // [RULE_09]
					`CMR_OP_BRPAIR:
						pc <= {gpr[{arg[1:0], 1'b1}], gpr[{arg[1:0], 1'b0}]}; // [RULE_09]
					`CMR_OP_TCALL:
						pc <= vecAt(ctIdx);                    // [RULE_05]
					`CMR_OP_PUSHPSW: begin
						if (pushOk)
							sp <= pushAddr;                    // [RULE_19]
					end
					`CMR_OP_POPPSW, `CMR_OP_IRET: begin
						if (popOk) begin
							program_status_word <= popData;                    // [RULE_11]
							sp <= sp + 16'h0001;               // [RULE_19]
						end
					end
					`CMR_OP_MASKALL:
						program_status_word[`CMR_PSW_IE] <= 1'b0;              // [RULE_14]
					`CMR_OP_UNMASK:
						program_status_word[`CMR_PSW_IE] <= 1'b1;              // [RULE_14]
					`CMR_OP_ADD: begin
						gpr[dst] <= addRes[7:0];
						program_status_word[`CMR_PSW_Z] <= addRes[7:0] == 8'h00;  // [RULE_15]
						program_status_word[`CMR_PSW_AC] <= addLow[4];             // [RULE_16]
						program_status_word[`CMR_PSW_CY] <= addRes[8];             // [RULE_17]
					end
					`CMR_OP_SUB: begin
						gpr[dst] <= subRes[7:0];
						program_status_word[`CMR_PSW_Z] <= subRes[7:0] == 8'h00;  // [RULE_15]
						program_status_word[`CMR_PSW_AC] <= subLow[4];             // [RULE_16]
						program_status_word[`CMR_PSW_CY] <= subRes[8];             // [RULE_17]
					end
					`CMR_OP_ROR: begin
						gpr[dst] <= {opA[0], opA[7:1]};
						program_status_word[`CMR_PSW_CY] <= opA[0];            // [RULE_17]
					end
					`CMR_OP_ROL: begin
						gpr[dst] <= {opA[6:0], opA[7]};
						program_status_word[`CMR_PSW_CY] <= opA[7];            // [RULE_17]
					end
					`CMR_OP_MOV1:
						program_status_word[`CMR_PSW_CY] <= bitVal;            // [RULE_17]
					`CMR_OP_AND1:
						program_status_word[`CMR_PSW_CY] <= program_status_word[`CMR_PSW_CY] & bitVal; // [RULE_17]
					`CMR_OP_LDREG:
						gpr[dst] <= dat[7:0];                  // [RULE_21]
					default: begin
					end
				endcase
			end
			// Direct register writes from the bus win over same-cycle updates
			if (wEn && dAddr == `CMR_OFS_PC)
				pc <= hwdata[15:0];
			if (wEn && dAddr == `CMR_OFS_PSW)
				program_status_word <= hwdata[7:0];
			if (wEn && dAddr == `CMR_OFS_SP)
				sp <= hwdata[15:0];                            // [RULE_18]
			if (wEn && dAddr == `CMR_OFS_MASK)
				irqMask <= hwdata[15:0];
			if (wEn && dAddr == `CMR_OFS_PROBE)
				probe <= hwdata[15:0];
			if (wEn && isGpr)
				gpr[dAddr[4:2]] <= hwdata[7:0];                // [RULE_22]
			if (wEn && isPair) begin
				gpr[{dAddr[3:2], 1'b0}] <= hwdata[7:0];        // [RULE_23]
				gpr[{dAddr[3:2], 1'b1}] <= hwdata[15:8];       // [RULE_23]
			end
		end
	end

endmodule

// ### dv/cmr_cpu_regs_sva.sv
`timescale 1ns/100ps
module cmr_cpu_regs_sva #(
	parameter NUM_SRC = 15
) (
	// Clock and reset
	input wire               core_clk,
	input wire               rst,
	// Register bus
	input wire               hsel,
	input wire [31:0]        haddr,
	input wire [1:0]         htrans,
	input wire               hwrite,
	input wire               hready,
	input wire [31:0]        hrdata,
	input wire               hreadyout,
	input wire               hresp,
	// Interrupt side
	input wire [NUM_SRC-1:0] irqReq,
	input wire               wdtReq,
	input wire               intAck
);
	// ----------------------------------------
	// Helper terms
	// ----------------------------------------
	wire rdTaken;
	wire wrTaken;

	// Address phases accepted by the slave
	assign rdTaken = hsel & htrans[1] & hready & ~hwrite;
	assign wrTaken = hsel & htrans[1] & hready & hwrite;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	// Read takes one wait state, then data stands
	sequence sRdAddr;
		rdTaken;
	endsequence
	sequence sRdData;
		!hreadyout ##1 hreadyout;
	endsequence

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_read_wait: assert property (sRdAddr |=> sRdData)
		else $error("read wait state wrong");
	a_write_nowait: assert property (wrTaken |=> hreadyout)
		else $error("write stalled");
	a_wait_cause: assert property (!hreadyout |-> $past(rdTaken))
		else $error("stall without read");
	a_resp_okay: assert property (!hresp)
		else $error("error response seen");
	a_data_holds: assert property ($changed(hrdata) |-> $past(rdTaken, 2))
		else $error("read data changed without read");
	a_unmapped_zero: assert property ((rdTaken && haddr[31:12] != 20'h0) |-> ##2 (hrdata == 32'h0))
		else $error("unmapped read not zero");
	a_ctrl_width: assert property ((rdTaken && (haddr == 32'h0 || haddr == 32'h8)) |-> ##2 (hrdata[31:16] == 16'h0))
		else $error("counter or pointer wider than 16 bits");
	a_psw_width: assert property ((rdTaken && haddr == 32'h4) |-> ##2 (hrdata[31:8] == 24'h0))
		else $error("status word wider than 8 bits");
	a_ack_single: assert property (intAck |=> !intAck)
		else $error("acknowledge longer than one cycle");
	a_no_cause: assert property ((!wdtReq && ~|irqReq) [*6] |-> !intAck)
		else $error("acknowledge without request");
endmodule

// ### dv/cmr_cpu_regs_tb_top.sv
`timescale 1ns/100ps
bind cmr_cpu_regs cmr_cpu_regs_sva #(.NUM_SRC(NUM_SRC)) u_cmr_cpu_regs_sva (
	.core_clk  (core_clk),
	.rst       (rst),
	.hsel      (hsel),
	.haddr     (haddr),
	.htrans    (htrans),
	.hwrite    (hwrite),
	.hready    (hready),
	.hrdata    (hrdata),
	.hreadyout (hreadyout),
	.hresp     (hresp),
	.irqReq    (irqReq),
	.wdtReq    (wdtReq),
	.intAck    (intAck)
);

module cmr_cpu_regs_tb_top;
	logic        core_clk;
	logic        rst;
	logic        hsel;
	logic        hwrite;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [14:0] irqReq;
	logic        wdtReq;
	wire  [31:0] hrdata;
	wire         hreadyout;
	wire         hresp;
	wire         intAck;
	logic [31:0] rdData;
	int          nMismatch;
	int          totalChecks;
	int          nAck = 0;

	// Rows: [47:44] 1 write / 0 read, [43:32] offset, [31:0] data or expected
	logic [47:0] rows [$] = '{
		48'h10400000A1B0, 48'h10440000A3B2, 48'h10480000A5B4, 48'h104C0000A7B6,
		48'h0020000000B0, 48'h0024000000A1, 48'h003C000000A7, 48'h00480000A5B4,
		48'h10280000005C, 48'h00440000A35C,
		48'h100000001000, 48'h100C00000501, 48'h000000001005, 48'h100CBEEF0002, 48'h00000000BEEF,
		48'h100C00000203, 48'h00000000A5B4,
		48'h15F8000000CD, 48'h15FC000000AB, 48'h100C00001F04, 48'h00000000ABCD,
		48'h100C00000009, 48'h000400000082, 48'h100C00000008, 48'h000400000002,
		48'h100C00000810, 48'h002000000051, 48'h000400000003,
		48'h100C00F80416, 48'h100C00080516, 48'h100C00002C10, 48'h003000000000, 48'h000400000053,
		48'h100C00002C11, 48'h0030000000F8, 48'h000400000013,
		48'h100C00000312, 48'h002C000000D1, 48'h100C00000313, 48'h002C000000A3, 48'h000400000013,
		48'h100C00000415, 48'h000400000012, 48'h100C00001C14, 48'h000400000013,
		48'h10080000FD01, 48'h100C00000005, 48'h00080000FD00, 48'h080000000013,
		48'h100400000041, 48'h100C00000006, 48'h000400000013, 48'h00080000FD01,
		48'h100C00000005, 48'h100400000000, 48'h100C00000007, 48'h000400000013, 48'h00080000FD01,
		48'h10080000FD00, 48'h100C00000005, 48'h00080000FD00, 48'h001000000001, 48'h101000000001,
		48'h001000000000, 48'h10080000FF00, 48'h100C00000006, 48'h00080000FF00, 48'h001000000001
	};
	// Probe rows: {region, address}
	logic [18:0] probes [$] = '{19'h00000, 19'h00021, 19'h20022, 19'h10040, 19'h1007F, 19'h20080,
		19'h2F9FF, 19'h3FA00, 19'h3FA0E, 19'h6FA0F, 19'h4FD00, 19'h4FEFF, 19'h5FF00, 19'h5FFFF};

	cmr_cpu_regs #(.NUM_SRC(15), .LARGE_DISP(1)) u_cmr_cpu_regs (
		.core_clk  (core_clk),
		.rst       (rst),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hreadyout),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.irqReq    (irqReq),
		.wdtReq    (wdtReq),
		.intAck    (intAck)
	);

	// ----------------------------------------
	// Clock and acknowledge counter
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// Counted on the clock so the bench never misses a one-cycle pulse
	always @(posedge core_clk) begin
		if (intAck === 1'b1) nAck <= nAck + 1;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task endSim;
		$display("checks %0d mismatches %0d", totalChecks, nMismatch);
		if (nMismatch == 0 && totalChecks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		totalChecks++;
		if (got !== exp) begin
			nMismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Waits for hready sampled high; bounded so a hung slave ends the run
	task waitReady;
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1) begin
			chk("bus ready", 32'h1, 32'h0);
			endSim;
		end
	endtask

	task busXfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= wr;
		waitReady;
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wr ? d : 32'h0;
		waitReady;
		rdData = hrdata;
	endtask

	task readChk(input logic [31:0] a, input logic [31:0] exp);
		busXfer(1'b0, a, 32'h0);
		chk($sformatf("addr %h", a), exp, rdData);
	endtask

	task waitAck;
		int n;
		int start;
		n = 0;
		start = nAck;
		while (nAck == start && n < 20) begin
			@(negedge core_clk);
			n++;
		end
		chk("acknowledge count", start + 1, nAck);
		// A lost acknowledge ends the run here rather than hanging later
		if (nAck == start) endSim;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		irqReq = 15'h0;
		wdtReq = 1'b0;
		nMismatch = 0;
		totalChecks = 0;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		// Table of ordinary register and command cases
		foreach (rows[i]) begin
			if (rows[i][44]) busXfer(1'b1, {20'h0, rows[i][43:32]}, rows[i][31:0]);
			else readChk({20'h0, rows[i][43:32]}, rows[i][31:0]);
		end
		// Region decode over the whole map
		foreach (probes[i]) begin
			busXfer(1'b1, 32'h18, {16'h0, probes[i][15:0]});
			readChk(32'h18, {13'h0, probes[i]});
		end
		// Masked source stays quiet, unmasked one vectors through slot 000CH
		busXfer(1'b1, 32'h430, 32'h78);
		busXfer(1'b1, 32'h434, 32'h56);
		busXfer(1'b1, 32'h410, 32'h9A);
		busXfer(1'b1, 32'h414, 32'hBC);
		busXfer(1'b1, 32'h8, 32'hFE00);
		busXfer(1'b1, 32'h4, 32'h80);
		@(posedge core_clk) irqReq <= 15'h0008;
		repeat (10) @(posedge core_clk);
		chk("masked acknowledge", 32'h0, nAck);
		busXfer(1'b1, 32'h14, 32'hFFF7);
		waitAck;
		@(posedge core_clk) irqReq <= 15'h0;
		readChk(32'h0, 32'h5678);
		readChk(32'h8, 32'hFDFF);
		readChk(32'hBFC, 32'h80);
		readChk(32'h4, 32'h00);
		// Watchdog is taken although the enable flag is clear
		@(posedge core_clk) wdtReq <= 1'b1;
		waitAck;
		@(posedge core_clk) wdtReq <= 1'b0;
		readChk(32'h0, 32'hBC9A);
		readChk(32'h8, 32'hFDFE);
		// Second reset fetches the vector from bytes 0000H and 0001H
		busXfer(1'b1, 32'h400, 32'h34);
		busXfer(1'b1, 32'h404, 32'h12);
		@(posedge core_clk) rst <= 1'b1;
		@(negedge core_clk);
		chk("reset outputs", 32'h1, {hresp, intAck, hreadyout});
		chk("reset read data", 32'h0, hrdata);
		// Two edges in reset so the cleared read data is already settled at release
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		readChk(32'h0, 32'h1234);
		readChk(32'h4, 32'h02);
		// Address outside the register page is ignored
		busXfer(1'b1, 32'h1004, 32'hFF);
		readChk(32'h1004, 32'h0);
		readChk(32'h4, 32'h02);
		endSim;
	end
endmodule
